/* hdl/sat_map.vh */
// Constants for the sector address translator
// What this block does
// (R1) Below capacity limit, a CHS default translation is selected after power-on reset.
// (R2) LBA translation is always available regardless of capacity.
// (R3) Above capacity limit, LBA is the default after power-on reset.
// (R4) Optional CHS translation above the limit exposes at most the limit in sectors.
// (R5) Small devices accept other geometries chosen by the initialise-parameters command.
// (R6) Sector field runs from 1 to current maximum, never above 255.
// (R7) Head field runs from 0 to current maximum, never above 15.
// (R8) Cylinder field runs from 0 to current maximum, never above 65535.
// (R9) Host gives sectors per track and heads; device computes cylinder count.
// (R10) Stepping increments sector first, then head, then cylinder.
// (R11) Addressing method is held for the whole command and used for reported addresses.
// (R12) Host picks CHS or LBA per command with the select bit.
// (R13) LBA accepted on every media command; format track too in this design.
// (R14) Select bit ignored for commands that do not touch media.
// (R15) LBA 0 equals C0/H0/S1 and LBA is independent of translation.
// (R16) LBA equals ((cyl*heads + head)*spt) + sector - 1.
// (R17) Sector register carries start sector in CHS, LBA bits 7-0 in LBA.
// (R18) Failed media command reloads address registers with failing address.
// (R19) Sector 0 or out-of-range CHS field aborts the command without media access.
`ifndef SAT_MAP_VH
`define SAT_MAP_VH
`define SAT_CHS_LIMIT 28'hfc0000
`define SAT_MAX_SECT 8'hff
`define SAT_MAX_HEAD 5'h10
`define SAT_MAX_CYL 17'h10000
`define SAT_DEF_SPT 8'h3f
`define SAT_DEF_HEADS 5'h10
`define SAT_ONE_SECT 8'h01
`define SAT_ST_IDLE 3'h0
`define SAT_ST_MUL1 3'h1
`define SAT_ST_MUL2 3'h2
`define SAT_ST_RUN 3'h3
`define SAT_ST_DIV 3'h4
`define SAT_DIV_STEPS 5'h1c
`define SAT_QUO_TOP 5'h11
`endif

/* hdl/sat_chs_step.v */
// Next CHS address in sequential order
`timescale 1ns/1ps
`include "sat_map.vh"
module sat_chs_step (
    // Current address
    input wire [7:0] sect,
    input wire [3:0] head,
    input wire [15:0] cyl,
    // Current geometry
    input wire [7:0] spt,
    input wire [4:0] heads,
    // Next address
    output reg [7:0] sect_nx,
    output reg [3:0] head_nx,
    output reg [15:0] cyl_nx
);
    always @* begin
        sect_nx = sect + `SAT_ONE_SECT; // R10
        head_nx = head;
        cyl_nx = cyl;
        if (sect >= spt) begin
            sect_nx = `SAT_ONE_SECT;
            head_nx = head + 4'h1; // R10
            if ({1'b0, head} >= heads - 5'h01) begin
                head_nx = 4'h0;
                cyl_nx = cyl + 16'h0001; // R10
            end
        end
    end
endmodule

/* hdl/sat_top.v */
// Sector address translator: geometry, range check, CHS to LBA, stepping
`timescale 1ns/1ps
`include "sat_map.vh"
module sat_top (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Device capacity in sectors
    input wire [27:0] capacity,
    // Geometry setup request
    input wire geo_set,
    input wire [7:0] geo_spt,
    input wire [3:0] geo_head_max,
    output wire geo_busy,
    // Command start
    input wire cmd_start,
    input wire cmd_media,
    input wire cmd_lba_sel,
    input wire [7:0] cmd_sect_num,
    input wire [7:0] cmd_cyl_lo,
    input wire [7:0] cmd_cyl_hi,
    input wire [3:0] cmd_head_lba,
    // Sector stepping and end of command
    input wire step,
    input wire cmd_end,
    input wire cmd_fail,
    // Results
    output reg chs_valid_q,
    output reg lba_mode_q,
    output reg cmd_active_q,
    output reg addr_ok_q,
    output reg abort_q,
    output reg [27:0] lba_q,
    output reg [7:0] spt_q,
    output reg [4:0] heads_q,
    output reg [15:0] cyl_max_q,
    // Address registers on error
    output reg err_load_q,
    output reg [7:0] err_sect_num_q,
    output reg [7:0] err_cyl_lo_q,
    output reg [7:0] err_cyl_hi_q,
    output reg [3:0] err_head_lba_q
);
    reg [2:0] st_q;
    reg [7:0] sect_q;
    reg [3:0] head_q;
    reg [15:0] cyl_q;
    reg [27:0] acc_q;
    reg [27:0] rem_q;
    reg [16:0] quo_q;
    reg [12:0] div_q;
    reg [4:0] cnt_q;
    reg init_q;
    wire [7:0] sect_nx;
    wire [3:0] head_nx;
    wire [15:0] cyl_nx;
    // Capacity that a CHS translation may expose
    wire big = capacity > `SAT_CHS_LIMIT;
    wire [27:0] cap_chs = big ? `SAT_CHS_LIMIT : capacity; // R4
    wire [7:0] in_s = cmd_sect_num;
    wire [15:0] in_c = {cmd_cyl_hi, cmd_cyl_lo};
    // Refusal check for a CHS start
    wire chs_ok = (in_s != 8'h00) && (in_s <= spt_q) && ({1'b0, cmd_head_lba} < heads_q)
        && ({1'b0, in_c} < {1'b0, cyl_max_q}); // R6 R7 R8 R19
    // Divisor shifted into place, wide enough that none of its bits fall off
    wire [40:0] div_sh = {28'h0, div_q} << (cnt_q - 5'h1);
    // Quotient bits above the top fold into it, so a huge count saturates
    wire [16:0] quo_bit = (cnt_q > `SAT_QUO_TOP) ? `SAT_MAX_CYL : (17'h1 << (cnt_q - 5'h1));
    assign geo_busy = (st_q == `SAT_ST_DIV) || !init_q;

    // Next address in sequential CHS order
    sat_chs_step u_step (
        .sect(sect_q),
        .head(head_q),
        .cyl(cyl_q),
        .spt(spt_q),
        .heads(heads_q),
        .sect_nx(sect_nx),
        .head_nx(head_nx),
        .cyl_nx(cyl_nx)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Geometry, command and conversion sequencing
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= `SAT_ST_IDLE;
            init_q <= 1'b0;
            chs_valid_q <= 1'b0;
            lba_mode_q <= 1'b0;
            cmd_active_q <= 1'b0;
            addr_ok_q <= 1'b0;
            abort_q <= 1'b0;
            lba_q <= 28'h0;
            spt_q <= `SAT_DEF_SPT;
            heads_q <= `SAT_DEF_HEADS;
            cyl_max_q <= 16'h0;
            sect_q <= 8'h0;
            head_q <= 4'h0;
            cyl_q <= 16'h0;
            acc_q <= 28'h0;
            rem_q <= 28'h0;
            quo_q <= 17'h0;
            div_q <= 13'h0;
            cnt_q <= 5'h0;
            err_load_q <= 1'b0;
            err_sect_num_q <= 8'h0;
            err_cyl_lo_q <= 8'h0;
            err_cyl_hi_q <= 8'h0;
            err_head_lba_q <= 4'h0;
        end else begin
            abort_q <= 1'b0;
            err_load_q <= 1'b0;
            case (st_q)
                `SAT_ST_IDLE: begin
                    if (!init_q) begin
                        // Default geometry after power-on; capacity picks the default method
                        init_q <= 1'b1;
                        chs_valid_q <= 1'b0;
                        lba_mode_q <= big; // R1 R3
                        div_q <= `SAT_DEF_SPT * `SAT_DEF_HEADS;
                        rem_q <= cap_chs;
                        quo_q <= 17'h0;
                        cnt_q <= `SAT_DIV_STEPS;
                        st_q <= `SAT_ST_DIV;
                    end else if (geo_set && !cmd_active_q && geo_spt != 8'h00) begin
                        // Host geometry: heads arrive as the highest head number
                        spt_q <= geo_spt; // R5 R9
                        heads_q <= {1'b0, geo_head_max} + 5'h01;
                        div_q <= geo_spt * ({1'b0, geo_head_max} + 5'h01);
                        rem_q <= cap_chs;
                        quo_q <= 17'h0;
                        cnt_q <= `SAT_DIV_STEPS;
                        chs_valid_q <= 1'b0;
                        st_q <= `SAT_ST_DIV;
                    end else if (cmd_start) begin
                        cmd_active_q <= 1'b1;
                        // Method is latched and held to the end of the command
                        lba_mode_q <= cmd_media & cmd_lba_sel; // R11 R12 R14
                        sect_q <= in_s; // R17
                        head_q <= cmd_head_lba;
                        cyl_q <= in_c;
                        if (!cmd_media) begin
                            addr_ok_q <= 1'b1; // R14
                            st_q <= `SAT_ST_RUN;
                        end else if (cmd_lba_sel) begin
                            // Packed head, cylinder high, cylinder low, sector
                            lba_q <= {cmd_head_lba, in_c, in_s}; // R2 R13 R17
                            addr_ok_q <= 1'b1;
                            st_q <= `SAT_ST_RUN;
                        end else if (!chs_valid_q || !chs_ok) begin
                            addr_ok_q <= 1'b0;
                            // Refused CHS address: no media access, one-cycle abort
                            abort_q <= 1'b1; // R19
                            cmd_active_q <= 1'b0;
                        end else begin
                            acc_q <= {12'h0, in_c} * {23'h0, heads_q} + {24'h0, cmd_head_lba}; // R16
                            st_q <= `SAT_ST_MUL1;
                        end
                    end
                end
                `SAT_ST_MUL1: begin
                    acc_q <= acc_q * {20'h0, spt_q}; // R16
                    st_q <= `SAT_ST_MUL2;
                end
                `SAT_ST_MUL2: begin
                    // Sector numbers start at 1, so one is taken off
                    lba_q <= acc_q + {20'h0, sect_q} - 28'h1; // R15 R16
                    addr_ok_q <= 1'b1;
                    st_q <= `SAT_ST_RUN;
                end
                `SAT_ST_RUN: begin
                    if (cmd_end || cmd_fail) begin
                        cmd_active_q <= 1'b0;
                        addr_ok_q <= 1'b0;
                        st_q <= `SAT_ST_IDLE;
                        if (cmd_fail) begin
                            // Failing address goes back in the command's own method
                            err_load_q <= 1'b1; // R18
                            if (lba_mode_q) begin
                                err_sect_num_q <= lba_q[7:0]; // R11 R17
                                err_cyl_lo_q <= lba_q[15:8];
                                err_cyl_hi_q <= lba_q[23:16];
                                err_head_lba_q <= lba_q[27:24];
                            end else begin
                                err_sect_num_q <= sect_q;
                                err_cyl_lo_q <= cyl_q[7:0];
                                err_cyl_hi_q <= cyl_q[15:8];
                                err_head_lba_q <= head_q;
                            end
                        end
                    end else if (step) begin
                        // The linear address follows the step in either method
                        if (lba_mode_q) begin
                            lba_q <= lba_q + 28'h1;
                        end else begin
                            sect_q <= sect_nx; // R10
                            head_q <= head_nx;
                            cyl_q <= cyl_nx;
                            lba_q <= lba_q + 28'h1; // R15
                        end
                    end
                end
                `SAT_ST_DIV: begin
                    // Restoring divide: cylinders = cap_chs / (spt * heads)
                    if (cnt_q != 5'h0) begin
                        cnt_q <= cnt_q - 5'h1;
                        if ({13'h0, rem_q} >= div_sh) begin
                            rem_q <= rem_q - div_sh[27:0];
                            quo_q <= quo_q | quo_bit;
                        end
                    end else begin
                        // Count saturates at the largest cylinder count
                        cyl_max_q <= (quo_q >= `SAT_MAX_CYL) ? 16'hffff : quo_q[15:0]; // R8 R9
                        chs_valid_q <= (quo_q != 17'h0);
                        st_q <= `SAT_ST_IDLE;
                    end
                end
                default: st_q <= `SAT_ST_IDLE;
            endcase
        end
    end
endmodule

/* verif/sat_chk.sv */
// Assertion checker for the sector address translator
`timescale 1ns/1ps
module sat_chk (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Requests
    input wire geo_busy,
    input wire cmd_start,
    input wire cmd_media,
    input wire cmd_lba_sel,
    input wire step,
    input wire cmd_end,
    input wire cmd_fail,
    input wire [7:0] cmd_sect_num,
    input wire [7:0] cmd_cyl_lo,
    input wire [7:0] cmd_cyl_hi,
    input wire [3:0] cmd_head_lba,
    // Results
    input wire [7:0] spt_q,
    input wire [4:0] heads_q,
    input wire [15:0] cyl_max_q,
    input wire [27:0] lba_q,
    input wire chs_valid_q,
    input wire lba_mode_q,
    input wire cmd_active_q,
    input wire addr_ok_q,
    input wire abort_q,
    input wire err_load_q,
    input wire [7:0] err_sect_num_q,
    input wire [7:0] err_cyl_lo_q,
    input wire [7:0] err_cyl_hi_q,
    input wire [3:0] err_head_lba_q
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
wire [15:0] cyl = {cmd_cyl_hi, cmd_cyl_lo};
wire [27:0] lba_in = {cmd_head_lba, cmd_cyl_hi, cmd_cyl_lo, cmd_sect_num};
wire [27:0] chs_lba = ({12'h0, cyl} * heads_q + cmd_head_lba) * spt_q + cmd_sect_num - 28'h1;
wire chs_ok = chs_valid_q && cmd_sect_num != 8'h0 && cmd_sect_num <= spt_q && cmd_head_lba < heads_q
    && cyl < cyl_max_q;
wire [27:0] err_all = {err_head_lba_q, err_cyl_hi_q, err_cyl_lo_q, err_sect_num_q};
sequence s_take;
    cmd_start && !geo_busy && !cmd_active_q;
endsequence
sequence s_chs;
    s_take ##0 (cmd_media && !cmd_lba_sel);
endsequence
lba_take_a: assert property (s_take ##0 (cmd_media && cmd_lba_sel) |=> addr_ok_q && lba_q == $past(lba_in))
    else $error("lba start not taken");
chs_map_a: assert property (s_chs ##0 chs_ok |-> ##3 addr_ok_q && lba_q == $past(chs_lba, 3))
    else $error("chs to lba wrong");
chs_bad_a: assert property (s_chs ##0 !chs_ok |=> abort_q && !addr_ok_q)
    else $error("bad chs not aborted");
abort_one_a: assert property (abort_q |=> !abort_q)
    else $error("abort longer than one cycle");
no_media_a: assert property (s_take ##0 !cmd_media |=> addr_ok_q && !abort_q)
    else $error("select bit not ignored");
step_lba_a: assert property (addr_ok_q && lba_mode_q && step |=> lba_q == $past(lba_q) + 28'h1)
    else $error("lba step wrong");
fail_err_a: assert property (cmd_active_q && lba_mode_q && cmd_fail |=> err_load_q && !cmd_active_q
    && err_all == $past(lba_q))
    else $error("failing lba not loaded");
end_ok_a: assert property (cmd_active_q && cmd_end |=> !cmd_active_q && !addr_ok_q && !err_load_q)
    else $error("command end wrong");
endmodule
bind sat_top sat_chk chk (
    .clk(clk),
    .rst_n(rst_n),
    .geo_busy(geo_busy),
    .cmd_start(cmd_start),
    .cmd_media(cmd_media),
    .cmd_lba_sel(cmd_lba_sel),
    .step(step),
    .cmd_end(cmd_end),
    .cmd_fail(cmd_fail),
    .cmd_sect_num(cmd_sect_num),
    .cmd_cyl_lo(cmd_cyl_lo),
    .cmd_cyl_hi(cmd_cyl_hi),
    .cmd_head_lba(cmd_head_lba),
    .spt_q(spt_q),
    .heads_q(heads_q),
    .cyl_max_q(cyl_max_q),
    .lba_q(lba_q),
    .chs_valid_q(chs_valid_q),
    .lba_mode_q(lba_mode_q),
    .cmd_active_q(cmd_active_q),
    .addr_ok_q(addr_ok_q),
    .abort_q(abort_q),
    .err_load_q(err_load_q),
    .err_sect_num_q(err_sect_num_q),
    .err_cyl_lo_q(err_cyl_lo_q),
    .err_cyl_hi_q(err_cyl_hi_q),
    .err_head_lba_q(err_head_lba_q)
);

/* verif/sat_host.sv */
// Host adapter model: geometry and command requests
`timescale 1ns/1ps
module sat_host (
    // Clock
    input wire clk,
    // Geometry request
    output reg geo_set,
    output reg [7:0] geo_spt,
    output reg [3:0] geo_head_max,
    // Command request
    output reg cmd_start,
    output reg cmd_media,
    output reg cmd_lba_sel,
    output reg [7:0] cmd_sect_num,
    output reg [7:0] cmd_cyl_lo,
    output reg [7:0] cmd_cyl_hi,
    output reg [3:0] cmd_head_lba,
    // Stepping and end of command
    output reg step,
    output reg cmd_end,
    output reg cmd_fail
);
// Drop every request back to its idle level
task idle;
    begin
        {geo_set, cmd_start, cmd_media, cmd_lba_sel, step, cmd_end, cmd_fail} = 7'h0;
        {geo_spt, geo_head_max, cmd_sect_num, cmd_cyl_lo, cmd_cyl_hi, cmd_head_lba} = 40'h0;
    end
endtask
task geo(input [7:0] spt, input [3:0] hmax);
    begin
        @(posedge clk) #1;
        {geo_spt, geo_head_max} = {spt, hmax};
        geo_set = 1'b1;
        @(posedge clk) #1;
        geo_set = 1'b0;
    end
endtask
// Address packed as head, cylinder high, cylinder low, sector
task send(input m, input l, input [27:0] a);
    begin
        @(posedge clk) #1;
        {cmd_head_lba, cmd_cyl_hi, cmd_cyl_lo, cmd_sect_num} = a;
        cmd_media = m;
        cmd_lba_sel = l;
        cmd_start = 1'b1;
        @(posedge clk) #1;
        cmd_start = 1'b0;
    end
endtask
// 0 step, 1 end, 2 fail
task pulse(input [1:0] k);
    begin
        @(posedge clk) #1;
        {cmd_fail, cmd_end, step} = 3'h1 << k;
        @(posedge clk) #1;
        {cmd_fail, cmd_end, step} = 3'h0;
    end
endtask
endmodule

/* verif/sat_top_tb.sv */
// Self-checking testbench for the sector address translator
`timescale 1ns/1ps
module sat_top_tb;
reg clk = 1'b0;
reg rst_n = 1'b0;
reg [27:0] capacity = 28'h0100000;
wire geo_set, cmd_start, cmd_media, cmd_lba_sel, step, cmd_end, cmd_fail, geo_busy;
wire [7:0] geo_spt, cmd_sect_num, cmd_cyl_lo, cmd_cyl_hi, spt_q, err_sect_num_q, err_cyl_lo_q, err_cyl_hi_q;
wire [3:0] geo_head_max, cmd_head_lba, err_head_lba_q;
wire chs_valid_q, lba_mode_q, cmd_active_q, addr_ok_q, abort_q, err_load_q;
wire [4:0] heads_q;
wire [15:0] cyl_max_q;
wire [27:0] lba_q;
integer err_count = 0;
integer check_count = 0;
integer cyc = 0;
always #5 clk = ~clk;
sat_host host (
    .clk(clk),
    .geo_set(geo_set),
    .geo_spt(geo_spt),
    .geo_head_max(geo_head_max),
    .cmd_start(cmd_start),
    .cmd_media(cmd_media),
    .cmd_lba_sel(cmd_lba_sel),
    .cmd_sect_num(cmd_sect_num),
    .cmd_cyl_lo(cmd_cyl_lo),
    .cmd_cyl_hi(cmd_cyl_hi),
    .cmd_head_lba(cmd_head_lba),
    .step(step),
    .cmd_end(cmd_end),
    .cmd_fail(cmd_fail)
);
sat_top dut (
    .clk(clk),
    .rst_n(rst_n),
    .capacity(capacity),
    .geo_set(geo_set),
    .geo_spt(geo_spt),
    .geo_head_max(geo_head_max),
    .geo_busy(geo_busy),
    .cmd_start(cmd_start),
    .cmd_media(cmd_media),
    .cmd_lba_sel(cmd_lba_sel),
    .cmd_sect_num(cmd_sect_num),
    .cmd_cyl_lo(cmd_cyl_lo),
    .cmd_cyl_hi(cmd_cyl_hi),
    .cmd_head_lba(cmd_head_lba),
    .step(step),
    .cmd_end(cmd_end),
    .cmd_fail(cmd_fail),
    .chs_valid_q(chs_valid_q),
    .lba_mode_q(lba_mode_q),
    .cmd_active_q(cmd_active_q),
    .addr_ok_q(addr_ok_q),
    .abort_q(abort_q),
    .lba_q(lba_q),
    .spt_q(spt_q),
    .heads_q(heads_q),
    .cyl_max_q(cyl_max_q),
    .err_load_q(err_load_q),
    .err_sect_num_q(err_sect_num_q),
    .err_cyl_lo_q(err_cyl_lo_q),
    .err_cyl_hi_q(err_cyl_hi_q),
    .err_head_lba_q(err_head_lba_q)
);
////////////////////////////////////////////////////////////////
task chk(input [8*12-1:0] name, input [31:0] seen, input [31:0] exp);
    begin
        check_count = check_count + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("BAD %0s expected %h seen %h", name, exp, seen);
        end
    end
endtask
task close_out;
    begin
        if (err_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
endtask
always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
        err_count = err_count + 1;
        close_out;
    end
end
////////////////////////////////////////////////////////////////
task wait_geo;
    integer n;
    begin
        n = 0;
        while (geo_busy !== 1'b0 && n < 100) begin
            @(posedge clk) #1;
            n = n + 1;
        end
        chk("geo_busy", geo_busy, 1'h0);
    end
endtask
task t_reset(input [27:0] cap, input lba, input [15:0] cyls);
    begin
        capacity = cap;
        rst_n = 1'b0;
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        wait_geo;
        chk("mode", {chs_valid_q, lba_mode_q}, {1'b1, lba});
        chk("geometry", {spt_q, heads_q, cyl_max_q}, {8'h3f, 5'h10, cyls});
    end
endtask
task t_chs(input [27:0] a, input [27:0] exp);
    begin
        host.send(1'b1, 1'b0, a);
        repeat (2) @(posedge clk);
        #1;
        chk("chs_lba", {addr_ok_q, lba_mode_q, lba_q}, {2'h2, exp});
        host.pulse(2'h1);
        chk("chs_end", cmd_active_q, 1'h0);
    end
endtask
task t_carry;
    begin
        host.send(1'b1, 1'b0, 28'hf00023f);
        repeat (2) @(posedge clk);
        #1;
        chk("carry_lba", lba_q, 28'hbcf);
        host.pulse(2'h0);
        host.pulse(2'h2);
        chk("carry_err", {err_load_q, err_head_lba_q, err_cyl_hi_q, err_cyl_lo_q, err_sect_num_q},
            {1'b1, 28'h0000301});
    end
endtask
task t_lba;
    begin
        host.send(1'b1, 1'b1, 28'h00f12ff);
        chk("lba_ok", {addr_ok_q, lba_mode_q, lba_q}, {2'h3, 28'h00f12ff});
        host.pulse(2'h0);
        host.pulse(2'h0);
        chk("lba_step", lba_q, 28'h00f1301);
        host.pulse(2'h2);
        chk("lba_err", {err_load_q, cmd_active_q, err_head_lba_q, err_cyl_hi_q, err_cyl_lo_q, err_sect_num_q},
            {2'h2, 28'h00f1301});
    end
endtask
task t_nomedia;
    begin
        host.send(1'b0, 1'b1, 28'h0);
        chk("nomedia", {addr_ok_q, abort_q}, 2'h2);
        host.pulse(2'h1);
    end
endtask
task t_abort(input [27:0] a);
    begin
        host.send(1'b1, 1'b0, a);
        chk("abort", {abort_q, addr_ok_q, cmd_active_q}, 3'h4);
    end
endtask
////////////////////////////////////////////////////////////////
initial begin
    host.idle;
    t_reset(28'h0100000, 1'b0, 16'h0410);
    t_chs(28'h0000001, 28'h0);
    t_chs(28'h1000001, 28'h3f);
    t_carry;
    t_lba;
    t_nomedia;
    t_abort(28'h0000000);
    t_abort(28'h0000040);
    t_abort(28'h0041001);
    host.geo(8'h11, 4'h3);
    wait_geo;
    chk("new_geo", {spt_q, heads_q, cyl_max_q}, {8'h11, 5'h04, 16'h3c3c});
    t_abort(28'h4000001);
    t_abort(28'h0000012);
    t_chs(28'h300000d, 28'h3f);
    t_chs(28'h3000111, 28'h87);
    host.geo(8'h01, 4'h0);
    wait_geo;
    chk("sat_geo", {spt_q, heads_q, cyl_max_q}, {8'h01, 5'h01, 16'hffff});
    t_reset(28'h1000000, 1'b1, 16'h4000);
    t_chs(28'h0000001, 28'h0);
    close_out;
end
endmodule
